/* File: hdl/dcc_chan_sel.sv */
// Per-channel selection of init controls and extended mode bank address.
// Assumes the per-channel control register lives outside and feeds own_ctl.
`timescale 1ns/1ps
module dcc_chan_sel
    import dcc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire dcc_chan_ctl_t shared_ctl,
    input  wire dcc_chan_ctl_t own_ctl,
    input  wire logic          indep,
    input  wire logic [1:0]    emrs_sel,
    output dcc_chan_ctl_t      ctl_r,
    output logic [2:0]         bank_r
);

    dcc_chan_ctl_t ctl_nxt;
    logic [2:0]    bank_nxt;

    // ==========================================================
    // Control source
    always_comb
    begin
        ctl_nxt = indep ? own_ctl : shared_ctl;
    end

    always_comb
    begin
        bank_nxt = DCC_BANK_NONE;
        // The reserved select issues no bank, so a stray code cannot hit bank 4.
        if (ctl_nxt.cmd == DCC_SMS_EMRS && emrs_sel != DCC_EMRS_RSVD)
        begin
            bank_nxt = {1'b0, emrs_sel} + DCC_BANK_STEP;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_r <= '0;
        end
        else
        begin
            ctl_r <= ctl_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bank_r <= DCC_BANK_NONE;
        end
        else
        begin
            bank_r <= bank_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_emrs_only;
        $past(ctl_nxt.cmd) != DCC_SMS_EMRS |-> bank_r == DCC_BANK_NONE;
    endproperty
    a_emrs_only: assert property (p_emrs_only) else $error("bank without emrs");

    property p_bank_code;
        ctl_nxt.cmd == DCC_SMS_EMRS && emrs_sel != DCC_EMRS_RSVD
            |=> bank_r == 3'($past(emrs_sel)) + DCC_BANK_STEP;
    endproperty
    a_bank_code: assert property (p_bank_code) else $error("bad bank code");

    property p_shared;
        !indep |=> ctl_r == $past(shared_ctl);
    endproperty
    a_shared: assert property (p_shared) else $error("shared ctl not used");

    property p_own;
        indep |=> ctl_r == $past(own_ctl);
    endproperty
    a_own: assert property (p_own) else $error("own ctl not used");

    c_emrs3: cover property (ctl_nxt.cmd == DCC_SMS_EMRS && emrs_sel == 2'h2 ##1 bank_r == 3'h3);

endmodule // dcc_chan_sel

/* File: hdl/dcc_pkg.sv */
// Constants and types for the memory channel control register bank.
// Assumes a 12-bit byte offset inside the chipset MMIO window and dword accesses.
package dcc_pkg;

    // ==========================================================
    // Register map
    localparam int          DCC_NUM_OPQ = 9;
    localparam logic [11:0] DCC_OFS_CHAN_CTL     = 12'h200;
    localparam logic [11:0] DCC_OFS_CHAN_CTL_TWO = 12'h204;
    // Opaque registers: fsb power 3/4, snoop, sleep timing, fsb power 5,
    // write cache, arbiter 0/1, sideband test.
    localparam logic [11:0] DCC_OPQ_OFS [DCC_NUM_OPQ] = '{
        12'h040, 12'h044, 12'h048, 12'h090, 12'h094,
        12'h218, 12'h220, 12'h224, 12'h230};
    localparam logic [31:0] DCC_OPQ_RST [DCC_NUM_OPQ] = '{
        32'h00000000, 32'h00000002, 32'h80800000, 32'h00005055, 32'h00010080,
        32'hA4008000, 32'h00000264, 32'h00000000, 32'h340A0000};
    localparam logic [31:0] DCC_CTL_RST      = 32'h00000000;
    localparam logic [31:0] DCC_CTL_TWO_RST  = 32'h00000000;

    // ==========================================================
    // Field layout
    localparam logic [31:0] DCC_CTL_RW_MASK      = 32'h1F7F8000;
    localparam logic [31:0] DCC_CTL_LOCK_MASK    = 32'h00000602;
    localparam logic [31:0] DCC_CTL_TWO_LOCK_MASK = 32'h0000FFFF;
    localparam int          DCC_EMRS_LSB  = 21;
    localparam int          DCC_INDEP_BIT = 20;
    localparam int          DCC_IC_BIT    = 19;
    localparam int          DCC_SMS_LSB   = 16;
    localparam int          DCC_XOR_BIT   = 10;
    localparam int          DCC_AMODE_BIT = 1;
    localparam int          DCC_MGMT_ENGINE_REGION_SIZE_W    = 16;
    localparam logic [2:0]  DCC_SMS_EMRS  = 3'h4;
    localparam logic [1:0]  DCC_EMRS_RSVD = 2'h3;
    localparam logic [2:0]  DCC_BANK_NONE = 3'h0;
    localparam logic [2:0]  DCC_BANK_STEP = 3'h1;

    // ==========================================================
    // Transaction steering
    localparam int DCC_INTLV_BIT = 6;
    localparam int DCC_XOR_LO    = 12;
    localparam int DCC_XOR_HI    = 19;

    typedef struct packed {
        logic       init_done;
        logic [2:0] cmd;
    } dcc_chan_ctl_t;

endpackage

/* File: hdl/dcc_regs.sv */
// Memory channel control register bank with its channel steering logic.
// Assumes dword-or-smaller aligned MMIO accesses from the host bridge decoder,
// a lock input from config space, and per-channel control and rank boundary
// values supplied by neighbouring blocks.
`timescale 1ns/1ps
module dcc_regs
    import dcc_pkg::*;
#(
    parameter int TXN_AW = 32
)
(
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [11:0]   MMIO_ADDR,
    input  wire logic          MMIO_WR,
    input  wire logic          MMIO_RD,
    input  wire logic [3:0]    MMIO_BE,
    input  wire logic [31:0]   MMIO_WDATA,
    output logic [31:0]        MMIO_RDATA,
    output logic               MMIO_RVALID,
    input  wire logic          LOCK,
    input  wire dcc_chan_ctl_t CH0_OWN_CTL,
    input  wire dcc_chan_ctl_t CH1_OWN_CTL,
    output dcc_chan_ctl_t      CH0_CTL,
    output dcc_chan_ctl_t      CH1_CTL,
    output logic [2:0]         CH0_BANK,
    output logic [2:0]         CH1_BANK,
    output logic               XOR_DISABLE,
    output logic               SYMMETRIC_MODE,
    output logic [15:0]        MGMT_REGION_SIZE,
    input  wire logic          TXN_VALID,
    input  wire logic [TXN_AW-1:0] TXN_ADDR,
    input  wire logic [TXN_AW-1:0] RANK_BOUND,
    output logic               TXN_CHAN_VALID,
    output logic               TXN_CHAN
);

    if (TXN_AW <= DCC_XOR_HI)
    begin : g_chk
        $error("TXN_AW too small for the XOR hash range");
    end

    logic [31:0] ctl_r;
    logic [31:0] ctl_nxt;
    logic [31:0] ctl_two_r;
    logic [31:0] ctl_two_nxt;
    logic [31:0] opq_r [DCC_NUM_OPQ];
    logic        lock_r;
    logic [31:0] be_mask;
    logic [31:0] rd_nxt;
    logic        chan_nxt;
    dcc_chan_ctl_t shared_ctl;

    assign be_mask = {{8{MMIO_BE[3]}}, {8{MMIO_BE[2]}}, {8{MMIO_BE[1]}}, {8{MMIO_BE[0]}}};
    assign shared_ctl = '{init_done: ctl_r[DCC_IC_BIT], cmd: ctl_r[DCC_SMS_LSB +: 3]};

    // ==========================================================
    // Lock
    // The lock is sticky so a glitch on the source cannot reopen the bits.
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            lock_r <= 1'b0;
        end
        else if (LOCK)
        begin
            lock_r <= 1'b1;
        end
    end

    // ==========================================================
    // Channel control registers
    always_comb
    begin
        logic [31:0] m;
        m = be_mask & (DCC_CTL_RW_MASK | (lock_r ? 32'h0 : DCC_CTL_LOCK_MASK));
        ctl_nxt = ctl_r;
        if (MMIO_WR && MMIO_ADDR == DCC_OFS_CHAN_CTL)
        begin
            ctl_nxt = (ctl_r & ~m) | (MMIO_WDATA & m);
        end
    end

    always_comb
    begin
        logic [31:0] m;
        m = lock_r ? 32'h0 : (be_mask & DCC_CTL_TWO_LOCK_MASK);
        ctl_two_nxt = ctl_two_r;
        if (MMIO_WR && MMIO_ADDR == DCC_OFS_CHAN_CTL_TWO)
        begin
            ctl_two_nxt = (ctl_two_r & ~m) | (MMIO_WDATA & m);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctl_r     <= DCC_CTL_RST;
            ctl_two_r <= DCC_CTL_TWO_RST;
        end
        else
        begin
            ctl_r     <= ctl_nxt;
            ctl_two_r <= ctl_two_nxt;
        end
    end

    // ==========================================================
    // Opaque registers
    // Bit-level access of these is not broken out, so they are held fully writable.
    always_ff @(posedge CLK)
    begin
        for (int i = 0; i < DCC_NUM_OPQ; i++)
        begin
            if (RESET)
            begin
                opq_r[i] <= DCC_OPQ_RST[i];
            end
            else if (MMIO_WR && MMIO_ADDR == DCC_OPQ_OFS[i])
            begin
                opq_r[i] <= (opq_r[i] & ~be_mask) | (MMIO_WDATA & be_mask);
            end
        end
    end

    // ==========================================================
    // Read path
    always_comb
    begin
        rd_nxt = 32'h0;
        if (MMIO_ADDR == DCC_OFS_CHAN_CTL)
        begin
            rd_nxt = ctl_r;
        end
        if (MMIO_ADDR == DCC_OFS_CHAN_CTL_TWO)
        begin
            rd_nxt = ctl_two_r;
        end
        for (int i = 0; i < DCC_NUM_OPQ; i++)
        begin
            if (MMIO_ADDR == DCC_OPQ_OFS[i])
            begin
                rd_nxt = opq_r[i];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            MMIO_RDATA  <= 32'h0;
            MMIO_RVALID <= 1'b0;
        end
        else
        begin
            MMIO_RVALID <= MMIO_RD;
            MMIO_RDATA  <= MMIO_RD ? rd_nxt : 32'h0;
        end
    end

    // ==========================================================
    // Decoded controls
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            XOR_DISABLE      <= 1'b0;
            SYMMETRIC_MODE   <= 1'b0;
            MGMT_REGION_SIZE <= 16'h0;
        end
        else
        begin
            XOR_DISABLE      <= ctl_r[DCC_XOR_BIT];
            SYMMETRIC_MODE   <= ctl_r[DCC_AMODE_BIT];
            MGMT_REGION_SIZE <= ctl_two_r[DCC_MGMT_ENGINE_REGION_SIZE_W-1:0];
        end
    end

    dcc_chan_sel u_ch0 (
        .clk        (CLK),
        .rst        (RESET),
        .shared_ctl (shared_ctl),
        .own_ctl    (CH0_OWN_CTL),
        .indep      (ctl_r[DCC_INDEP_BIT]),
        .emrs_sel   (ctl_r[DCC_EMRS_LSB +: 2]),
        .ctl_r      (CH0_CTL),
        .bank_r     (CH0_BANK)
    );

    dcc_chan_sel u_ch1 (
        .clk        (CLK),
        .rst        (RESET),
        .shared_ctl (shared_ctl),
        .own_ctl    (CH1_OWN_CTL),
        .indep      (ctl_r[DCC_INDEP_BIT]),
        .emrs_sel   (ctl_r[DCC_EMRS_LSB +: 2]),
        .ctl_r      (CH1_CTL),
        .bank_r     (CH1_BANK)
    );

    // ==========================================================
    // Transaction steering
    // Symmetric mode interleaves on a fixed address bit, optionally hashed with
    // upper bits; asymmetric mode fills channel 0 up to the rank boundary first.
    always_comb
    begin
        if (ctl_r[DCC_AMODE_BIT])
        begin
            chan_nxt = TXN_ADDR[DCC_INTLV_BIT]
                ^ (!ctl_r[DCC_XOR_BIT] & (^TXN_ADDR[DCC_XOR_HI:DCC_XOR_LO]));
        end
        else
        begin
            chan_nxt = TXN_ADDR >= RANK_BOUND;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            TXN_CHAN_VALID <= 1'b0;
            TXN_CHAN       <= 1'b0;
        end
        else
        begin
            TXN_CHAN_VALID <= TXN_VALID;
            TXN_CHAN       <= TXN_VALID ? chan_nxt : 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_ic_write;
        MMIO_WR && MMIO_ADDR == DCC_OFS_CHAN_CTL && MMIO_BE[2]
            |=> ctl_r[DCC_IC_BIT] == $past(MMIO_WDATA[DCC_IC_BIT]);
    endproperty
    a_ic_write: assert property (p_ic_write) else $error("init flag not written");

    property p_sms_write;
        MMIO_WR && MMIO_ADDR == DCC_OFS_CHAN_CTL && MMIO_BE[2] |=> ##1
            CH0_CTL.cmd == $past(MMIO_WDATA[DCC_SMS_LSB +: 3], 2) || $past(ctl_r[DCC_INDEP_BIT]);
    endproperty
    a_sms_write: assert property (p_sms_write) else $error("cmd select wrong");

    property p_xor_out;
        ##1 XOR_DISABLE == $past(ctl_r[DCC_XOR_BIT]);
    endproperty
    a_xor_out: assert property (p_xor_out) else $error("xor disable stale");

    property p_amode_steer;
        TXN_VALID && !ctl_r[DCC_AMODE_BIT] |=> TXN_CHAN == ($past(TXN_ADDR) >= $past(RANK_BOUND));
    endproperty
    a_amode_steer: assert property (p_amode_steer) else $error("asym steer wrong");

    property p_mgmt_engine_region_size_locked;
        lock_r |=> $stable(ctl_two_r[DCC_MGMT_ENGINE_REGION_SIZE_W-1:0]) ##1 $stable(MGMT_REGION_SIZE);
    endproperty
    a_mgmt_engine_region_size_locked: assert property (p_mgmt_engine_region_size_locked) else $error("region size moved");

    property p_sym_steer;
        TXN_VALID && ctl_r[DCC_AMODE_BIT] && ctl_r[DCC_XOR_BIT]
            |=> TXN_CHAN == $past(TXN_ADDR[DCC_INTLV_BIT]);
    endproperty
    a_sym_steer: assert property (p_sym_steer) else $error("sym steer wrong");

    property p_lock_bits;
        lock_r |=> $stable(ctl_r & DCC_CTL_LOCK_MASK);
    endproperty
    a_lock_bits: assert property (p_lock_bits) else $error("locked bit moved");

    property p_rd_answer;
        MMIO_RD |=> MMIO_RVALID ##1 !MMIO_RVALID || $past(MMIO_RD);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

    c_lock_write: cover property (lock_r && MMIO_WR && MMIO_ADDR == DCC_OFS_CHAN_CTL);
    c_indep: cover property (ctl_r[DCC_INDEP_BIT] ##1 CH1_CTL == CH1_OWN_CTL);
    c_sym_xor: cover property (TXN_VALID && ctl_r[DCC_AMODE_BIT] && !ctl_r[DCC_XOR_BIT]);
endmodule // dcc_regs

/* File: verif/dcc_regs_tb.sv */
// Self-checking bench for the memory channel control register bank.
// Assumes the package and design files under hdl/ are compiled first.
`timescale 1ns/1ps
module dram_channel_control_regs_tb_top;
    import dcc_pkg::*;

    // ==========================================================
    // Stimulus and observation
    logic          CLK;
    logic          RESET;
    logic [11:0]   MMIO_ADDR;
    logic          MMIO_WR;
    logic          MMIO_RD;
    logic [3:0]    MMIO_BE;
    logic [31:0]   MMIO_WDATA;
    logic [31:0]   MMIO_RDATA;
    logic          MMIO_RVALID;
    logic          LOCK;
    dcc_chan_ctl_t CH0_OWN_CTL;
    dcc_chan_ctl_t CH1_OWN_CTL;
    dcc_chan_ctl_t CH0_CTL;
    dcc_chan_ctl_t CH1_CTL;
    logic [2:0]    CH0_BANK;
    logic [2:0]    CH1_BANK;
    logic          XOR_DISABLE;
    logic          SYMMETRIC_MODE;
    logic [15:0]   MGMT_REGION_SIZE;
    logic          TXN_VALID;
    logic [31:0]   TXN_ADDR;
    logic [31:0]   RANK_BOUND;
    logic          TXN_CHAN_VALID;
    logic          TXN_CHAN;
    int            err_total;
    int            n_checks;
    int            cycles;
    logic [31:0]   rdat;

    dcc_regs #(.TXN_AW(32)) dut (
        .CLK(CLK), .RESET(RESET), .MMIO_ADDR(MMIO_ADDR), .MMIO_WR(MMIO_WR),
        .MMIO_RD(MMIO_RD), .MMIO_BE(MMIO_BE), .MMIO_WDATA(MMIO_WDATA),
        .MMIO_RDATA(MMIO_RDATA), .MMIO_RVALID(MMIO_RVALID), .LOCK(LOCK),
        .CH0_OWN_CTL(CH0_OWN_CTL), .CH1_OWN_CTL(CH1_OWN_CTL), .CH0_CTL(CH0_CTL),
        .CH1_CTL(CH1_CTL), .CH0_BANK(CH0_BANK), .CH1_BANK(CH1_BANK),
        .XOR_DISABLE(XOR_DISABLE), .SYMMETRIC_MODE(SYMMETRIC_MODE),
        .MGMT_REGION_SIZE(MGMT_REGION_SIZE), .TXN_VALID(TXN_VALID),
        .TXN_ADDR(TXN_ADDR), .RANK_BOUND(RANK_BOUND),
        .TXN_CHAN_VALID(TXN_CHAN_VALID), .TXN_CHAN(TXN_CHAN)
    );

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ==========================================================
    // Shared tasks
    task automatic conclude;
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // The ceiling is about eighty times the roughly 250 cycles the scenarios need.
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge CLK);
        MMIO_ADDR = a;
        MMIO_WDATA = d;
        MMIO_BE = be;
        MMIO_WR = 1'b1;
        @(negedge CLK);
        MMIO_WR = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge CLK);
        MMIO_ADDR = a;
        MMIO_RD = 1'b1;
        @(negedge CLK);
        MMIO_RD = 1'b0;
        chk("read valid", {31'h0, MMIO_RVALID}, 32'h00000001);
        chk("read data", MMIO_RDATA, exp);
    endtask

    // Reference steering, written independently of the design's own logic.
    function automatic logic exp_chan(input logic [31:0] a, input logic [31:0] ctl);
        if (ctl[1])
            return a[6] ^ (ctl[10] ? 1'b0 : ^a[19:12]);
        return a >= RANK_BOUND;
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_reset_map;
        for (int i = 0; i < DCC_NUM_OPQ; i++)
            rd(DCC_OPQ_OFS[i], DCC_OPQ_RST[i]);
        rd(12'h200, 32'h00000000);
        rd(12'h204, 32'h00000000);
        wr(12'h208, 32'hFFFFFFFF, 4'hF);
        rd(12'h208, 32'h00000000);
        wr(12'h218, 32'h12345678, 4'hF);
        rd(12'h218, 32'h12345678);
        wr(12'h218, 32'hA4008000, 4'hF);
        rd(12'h218, 32'hA4008000);
    endtask

    task automatic t_fields;
        wr(12'h200, 32'hFFFFFFFF, 4'hF);
        rd(12'h200, 32'h1F7F8602);
        chk("xor disable", {31'h0, XOR_DISABLE}, 32'h00000001);
        chk("symmetric", {31'h0, SYMMETRIC_MODE}, 32'h00000001);
        wr(12'h200, 32'h00000000, 4'hF);
        tick(2);
        chk("xor disable", {31'h0, XOR_DISABLE}, 32'h00000000);
    endtask

    task automatic t_shared_emrs;
        logic [2:0] bank;
        for (int c = 0; c < 8; c++)
            for (int s = 0; s < 4; s++)
            begin
                wr(12'h200, (32'(s) << 21) | (32'(c[0]) << 19) | (32'(c) << 16), 4'hF);
                tick(2);
                bank = (c == 4 && s != 3) ? 3'(s + 1) : 3'h0;
                chk("ch0 bank", {29'h0, CH0_BANK}, {29'h0, bank});
                chk("ch1 bank", {29'h0, CH1_BANK}, {29'h0, bank});
                chk("ch0 ctl", {28'h0, CH0_CTL}, {28'h0, c[0], 3'(c)});
                chk("ch1 ctl", {28'h0, CH1_CTL}, {28'h0, c[0], 3'(c)});
            end
    endtask

    task automatic t_independent;
        CH0_OWN_CTL = '{init_done: 1'b0, cmd: 3'h4};
        CH1_OWN_CTL = '{init_done: 1'b1, cmd: 3'h2};
        wr(12'h200, 32'h003B0000, 4'hF);
        tick(2);
        chk("ch0 ctl", {28'h0, CH0_CTL}, 32'h00000004);
        chk("ch1 ctl", {28'h0, CH1_CTL}, 32'h0000000A);
        chk("ch0 bank", {29'h0, CH0_BANK}, 32'h00000002);
        chk("ch1 bank", {29'h0, CH1_BANK}, 32'h00000000);
        CH1_OWN_CTL = '{init_done: 1'b1, cmd: 3'h4};
        tick(2);
        chk("ch1 bank", {29'h0, CH1_BANK}, 32'h00000002);
    endtask

    task automatic t_steering;
        logic [31:0] modes [3] = '{32'h00000000, 32'h00000002, 32'h00000402};
        logic [31:0] addrs [5] = '{32'h00000040, 32'h00001000, 32'h00101040,
                                   32'h000FFFFF, 32'h00100000};
        RANK_BOUND = 32'h00100000;
        foreach (modes[m])
        begin
            wr(12'h200, modes[m], 4'hF);
            tick(2);
            foreach (addrs[k])
            begin
                TXN_VALID = 1'b1;
                TXN_ADDR = addrs[k];
                @(negedge CLK);
                TXN_VALID = 1'b0;
                chk("txn valid", {31'h0, TXN_CHAN_VALID}, 32'h00000001);
                chk("txn chan", {31'h0, TXN_CHAN}, {31'h0, exp_chan(addrs[k], modes[m])});
            end
        end
    endtask

    task automatic t_lock;
        wr(12'h204, 32'h00001234, 4'hF);
        wr(12'h204, 32'hFFFFFFFF, 4'h2);
        rd(12'h204, 32'h0000FF34);
        chk("region size", {16'h0, MGMT_REGION_SIZE}, 32'h0000FF34);
        @(negedge CLK);
        LOCK = 1'b1;
        @(negedge CLK);
        LOCK = 1'b0;
        wr(12'h204, 32'h00000000, 4'hF);
        rd(12'h204, 32'h0000FF34);
        wr(12'h200, 32'hFFFFF9FD, 4'hF);
        rd(12'h200, 32'h1F7F8402);
        RESET = 1'b1;
        tick(10);
        RESET = 1'b0;
        rd(12'h204, 32'h00000000);
        chk("xor disable", {31'h0, XOR_DISABLE}, 32'h00000000);
        wr(12'h204, 32'h00000055, 4'hF);
        rd(12'h204, 32'h00000055);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        RESET = 1'b1;
        MMIO_ADDR = 12'h000;
        MMIO_WR = 1'b0;
        MMIO_RD = 1'b0;
        MMIO_BE = 4'h0;
        MMIO_WDATA = 32'h00000000;
        LOCK = 1'b0;
        CH0_OWN_CTL = '0;
        CH1_OWN_CTL = '0;
        TXN_VALID = 1'b0;
        TXN_ADDR = 32'h00000000;
        RANK_BOUND = 32'h00000000;
        tick(10);
        RESET = 1'b0;
        t_reset_map();
        t_fields();
        t_shared_emrs();
        t_independent();
        t_steering();
        t_lock();
        conclude();
    end

endmodule // dram_channel_control_regs_tb_top
